// ### rail_group_pkg.sv
/*
 * Constants for the switch/regulator group enable gating block:
 * register offsets, field positions, reset values, delay table, timing.
 * Assumes a 250 MHz core clock.
 */
`default_nettype none

package rail_group_pkg;

    // register offsets on the device's register port
    localparam logic [7:0] OFS_PG_MASK_RAILS_A = 8'h25;
    localparam logic [7:0] OFS_PIN_SELECT_PG_CLASS = 8'h26;
    localparam logic [7:0] OFS_ENABLE_EDGE_DELAYS = 8'h27;

    // values after reset
    localparam logic [7:0] RST_PG_MASK_RAILS_A = 8'h00;
    localparam logic [7:0] RST_PIN_SELECT_PG_CLASS = 8'h00;
    localparam logic [7:0] RST_ENABLE_EDGE_DELAYS = 8'h00;

    // field positions in the second register
    localparam int THIRD_REG_PG_MASK_BIT = 0;
    localparam int FIRST_SWITCH_PG_MASK_BIT = 1;
    localparam int SRC_SEL_LSB = 2;
    localparam int PG_CLASS_LSB = 5;
    // field positions in the third register
    localparam int RISE_DLY_LSB = 0;
    localparam int FALL_DLY_LSB = 3;

    // enable source select codes
    localparam logic [2:0] SRC_CONTROL_PIN_1 = 3'h0;
    localparam logic [2:0] SRC_CTL2 = 3'h1;
    localparam logic [2:0] SRC_CTL5 = 3'h2;
    localparam logic [2:0] SRC_CONTROL_PIN_4 = 3'h3;
    localparam logic [2:0] SRC_CONTROL_PIN_3 = 3'h4;
    localparam logic [2:0] SRC_CONTROL_PIN_3_AND_4 = 3'h5;
    localparam logic [2:0] SRC_CONTROL_PIN_6 = 3'h6;
    localparam logic [2:0] SRC_FORCED_ON = 3'h7;

    // timing: clock rate and one millisecond in cycles
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int MS_PER_UNIT = 1;
    localparam int TICKS_PER_MS = CLK_FREQ_KHZ * MS_PER_UNIT;
    localparam int DLY_CNT_W = 24;

    // nominal edge delay per code, in ms
    function automatic int dly_ms(input logic [2:0] code);
        unique case (code)
            3'h0: dly_ms = 0;
            3'h1: dly_ms = 2;
            3'h2: dly_ms = 4;
            3'h3: dly_ms = 8;
            3'h4: dly_ms = 16;
            3'h5: dly_ms = 24;
            3'h6: dly_ms = 32;
            3'h7: dly_ms = 64;
        endcase
    endfunction

endpackage

`default_nettype wire

// ### rail_enable_gating_logic.sv
/*
 * Enable gating for the combined load switch / general regulator group.
 * Picks the enable source from the control pins, delays its edges,
 * gates it with the unmasked power-good flags of the other rails.
 * Assumes control pins and power-good flags are asynchronous to core_clk_i
 * and that the register port is driven from core_clk_i logic.
 */
`timescale 1ns/1ns
`default_nettype none

module rail_enable_gating_logic #(
    parameter int TICKS_PER_MS = rail_group_pkg::TICKS_PER_MS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // control pins 1..6, bit 0 is pin 1
    input wire logic [5:0] control_pin_i,
    // power-good flags: [5:0] step-down rails 1..6, [6] other load switch,
    // [7] second small regulator, [8] third small regulator, [9] first load switch
    input wire logic [9:0] power_good_flag_i,
    // group outputs
    output logic switch_ldo_group_en_o,
    output logic [1:0] pg_voltage_class_o
);

    typedef enum logic [1:0] {
        GRP_OFF = 2'b00,
        GRP_RISING = 2'b01,
        GRP_ON = 2'b11,
        GRP_FALLING = 2'b10
    } grp_state_e;

    // counter width, declared ahead of the casts that use it
    localparam int DLY_CNT_W = rail_group_pkg::DLY_CNT_W;

    // register file
    logic [7:0] group_pg_mask_rails_a, next_group_pg_mask_rails_a;
    logic [7:0] group_pin_select_pg_class, next_group_pin_select_pg_class;
    logic [7:0] group_enable_edge_delays, next_group_enable_edge_delays;
    logic [7:0] next_reg_rdata;

    // synchronisers
    logic [5:0] ctl_meta, ctl_sync;
    logic [9:0] pg_meta, pg_sync;

    // sequencing
    grp_state_e state, next_state;
    logic [rail_group_pkg::DLY_CNT_W-1:0] cnt, next_cnt;
    logic next_en;
    logic [2:0] enable_source_select, rise_delay_code, fall_delay_code;
    logic [9:0] pg_mask;
    logic src_on, pg_ok;
    logic [rail_group_pkg::DLY_CNT_W-1:0] rise_limit, fall_limit;

    // register writes and registered read data; reserved bits simply store
    always_comb begin
        next_group_pg_mask_rails_a = group_pg_mask_rails_a;
        next_group_pin_select_pg_class = group_pin_select_pg_class;
        next_group_enable_edge_delays = group_enable_edge_delays;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                rail_group_pkg::OFS_PG_MASK_RAILS_A: next_group_pg_mask_rails_a = reg_wdata_i;
                rail_group_pkg::OFS_PIN_SELECT_PG_CLASS: next_group_pin_select_pg_class = reg_wdata_i;
                rail_group_pkg::OFS_ENABLE_EDGE_DELAYS: next_group_enable_edge_delays = reg_wdata_i;
                default: ;
            endcase
        end
        unique case (reg_addr_i)
            rail_group_pkg::OFS_PG_MASK_RAILS_A: next_reg_rdata = group_pg_mask_rails_a;
            rail_group_pkg::OFS_PIN_SELECT_PG_CLASS: next_reg_rdata = group_pin_select_pg_class;
            rail_group_pkg::OFS_ENABLE_EDGE_DELAYS: next_reg_rdata = group_enable_edge_delays;
            default: next_reg_rdata = 8'h00; // unmapped reads as zero
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            group_pg_mask_rails_a <= rail_group_pkg::RST_PG_MASK_RAILS_A;
            group_pin_select_pg_class <= rail_group_pkg::RST_PIN_SELECT_PG_CLASS;
            group_enable_edge_delays <= rail_group_pkg::RST_ENABLE_EDGE_DELAYS;
            reg_rdata_o <= 8'h00;
        end else begin
            group_pg_mask_rails_a <= next_group_pg_mask_rails_a;
            group_pin_select_pg_class <= next_group_pin_select_pg_class;
            group_enable_edge_delays <= next_group_enable_edge_delays;
            reg_rdata_o <= next_reg_rdata;
        end
    end

    // two-flop synchronisers; only the second stage feeds logic
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ctl_meta <= 6'h00;
            ctl_sync <= 6'h00;
            pg_meta <= 10'h000;
            pg_sync <= 10'h000;
        end else begin
            ctl_meta <= control_pin_i;
            ctl_sync <= ctl_meta;
            pg_meta <= power_good_flag_i;
            pg_sync <= pg_meta;
        end
    end

    // field extraction
    assign enable_source_select = group_pin_select_pg_class[rail_group_pkg::SRC_SEL_LSB +: 3];
    assign rise_delay_code = group_enable_edge_delays[rail_group_pkg::RISE_DLY_LSB +: 3];
    assign fall_delay_code = group_enable_edge_delays[rail_group_pkg::FALL_DLY_LSB +: 3];
    assign pg_voltage_class_o = group_pin_select_pg_class[rail_group_pkg::PG_CLASS_LSB +: 2];

    // a set mask bit excludes its flag; 0 keeps it in the condition
    assign pg_mask = {group_pin_select_pg_class[rail_group_pkg::FIRST_SWITCH_PG_MASK_BIT],
                      group_pin_select_pg_class[rail_group_pkg::THIRD_REG_PG_MASK_BIT],
                      group_pg_mask_rails_a};
    assign pg_ok = &(pg_sync | pg_mask);

    // enable source mux
    always_comb begin
        unique case (enable_source_select)
            rail_group_pkg::SRC_CONTROL_PIN_1: src_on = ctl_sync[0];
            rail_group_pkg::SRC_CTL2: src_on = ctl_sync[1];
            rail_group_pkg::SRC_CTL5: src_on = ctl_sync[4];
            rail_group_pkg::SRC_CONTROL_PIN_4: src_on = ctl_sync[3];
            rail_group_pkg::SRC_CONTROL_PIN_3: src_on = ctl_sync[2];
            rail_group_pkg::SRC_CONTROL_PIN_3_AND_4: src_on = ctl_sync[2] & ctl_sync[3];
            rail_group_pkg::SRC_CONTROL_PIN_6: src_on = ctl_sync[5];
            rail_group_pkg::SRC_FORCED_ON: src_on = 1'b1;
        endcase
    end

    // delay limits in cycles; exact nominal, inside the allowed spread
    assign rise_limit = DLY_CNT_W'(rail_group_pkg::dly_ms(rise_delay_code) * TICKS_PER_MS);
    assign fall_limit = DLY_CNT_W'(rail_group_pkg::dly_ms(fall_delay_code) * TICKS_PER_MS);

    // edge delay sequencer; a source glitch shorter than the delay is dropped
    always_comb begin
        next_state = state;
        next_cnt = cnt + 1'b1;
        unique case (state)
            GRP_OFF: begin
                next_cnt = '0;
                if (src_on) begin
                    next_state = (rise_delay_code == 3'h0) ? GRP_ON : GRP_RISING;
                end
            end
            GRP_RISING: begin
                if (!src_on) begin
                    next_state = GRP_OFF;
                end else if ((cnt + 1'b1) >= rise_limit) begin // code cut to 0 mid-wait ends it at once
                    next_state = GRP_ON;
                end
            end
            GRP_ON: begin
                next_cnt = '0;
                if (!src_on) begin
                    next_state = (fall_delay_code == 3'h0) ? GRP_OFF : GRP_FALLING;
                end
            end
            GRP_FALLING: begin
                if (src_on) begin
                    next_state = GRP_ON;
                end else if ((cnt + 1'b1) >= fall_limit) begin
                    next_state = GRP_OFF;
                end
            end
        endcase
        if (next_state != state) begin
            next_cnt = '0;
        end
        // delayed source and unmasked power-good flags together
        next_en = (next_state == GRP_ON || next_state == GRP_FALLING) && pg_ok;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state <= GRP_OFF;
            cnt <= '0;
            switch_ldo_group_en_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            switch_ldo_group_en_o <= next_en;
        end
    end

    // checks
    property p_rails_a_mask;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (|(~group_pg_mask_rails_a[4:0] & ~pg_sync[4:0])) |=> !switch_ldo_group_en_o;
    endproperty
    a_rails_a_mask: assert property (p_rails_a_mask) else $error("unmasked low rail flag let group on");

    property p_rails_b_mask;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (|(~group_pg_mask_rails_a[7:5] & ~pg_sync[7:5])) |=> !switch_ldo_group_en_o;
    endproperty
    a_rails_b_mask: assert property (p_rails_b_mask) else $error("unmasked flag 5..7 let group on");

    property p_third_reg_mask;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (!group_pin_select_pg_class[0] && !pg_sync[8]) |=> !switch_ldo_group_en_o;
    endproperty
    a_third_reg_mask: assert property (p_third_reg_mask) else $error("third regulator flag ignored");

    property p_first_switch_mask;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (!group_pin_select_pg_class[1] && !pg_sync[9]) |=> !switch_ldo_group_en_o;
    endproperty
    a_first_switch_mask: assert property (p_first_switch_mask) else $error("first switch flag ignored");

    property p_src_pin3_and_4;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (enable_source_select == rail_group_pkg::SRC_CONTROL_PIN_3_AND_4) |-> (src_on == (ctl_sync[2] && ctl_sync[3]));
    endproperty
    a_src_pin3_and_4: assert property (p_src_pin3_and_4) else $error("pin3 and pin4 source wrong");

    property p_forced_on;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (enable_source_select == rail_group_pkg::SRC_FORCED_ON && state == GRP_OFF && rise_delay_code == 3'h0
         && pg_ok) |=> switch_ldo_group_en_o;
    endproperty
    a_forced_on: assert property (p_forced_on) else $error("forced source did not enable");

    property p_class_write;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == rail_group_pkg::OFS_PIN_SELECT_PG_CLASS)
        |=> pg_voltage_class_o == $past(reg_wdata_i[6:5]);
    endproperty
    a_class_write: assert property (p_class_write) else $error("class field not stored");

    sequence s_rise_wait;
        state == GRP_RISING && src_on && (cnt + 1'b1) >= rise_limit;
    endsequence
    property p_rise_bound;
        @(posedge core_clk_i) disable iff (!nrst_i)
        s_rise_wait |=> state == GRP_ON && switch_ldo_group_en_o == $past(pg_ok);
    endproperty
    a_rise_bound: assert property (p_rise_bound) else $error("rising delay overran");

    property p_fall_now;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state == GRP_ON && !src_on && fall_delay_code == 3'h0) |=> state == GRP_OFF && !switch_ldo_group_en_o;
    endproperty
    a_fall_now: assert property (p_fall_now) else $error("undelayed fall not immediate");

    property p_en_cause;
        @(posedge core_clk_i) disable iff (!nrst_i)
        switch_ldo_group_en_o |-> $past(pg_ok) && (state == GRP_ON || state == GRP_FALLING);
    endproperty
    a_en_cause: assert property (p_en_cause) else $error("group on without cause");

endmodule // rail_enable_gating_logic

`default_nettype wire

// ### host_model.sv
/* host side model: register writes/reads and control pin, power-good drive.
   assumes the bench calls its tasks and a single core clock. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // clock and read data
    input wire logic clk_i,
    input wire logic [7:0] reg_rdata_i,
    // register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    // pins and flags
    output logic [5:0] control_pin_o,
    output logic [9:0] power_good_flag_o
);
    // idle values at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        control_pin_o = 6'h00;
        power_good_flag_o = 10'h000;
    end
    // one-cycle write; data inverted after so stale data is never reused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask
    // read data is registered, so wait two edges
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
    // pins and flags change together
    task automatic drive(input logic [5:0] p, input logic [9:0] g);
        @(posedge clk_i);
        control_pin_o <= p;
        power_good_flag_o <= g;
    endtask
endmodule // host_model
`default_nettype wire

// ### rail_enable_gating_logic_test.sv
/* self-checking bench for the group enable gating block.
   assumes host_model drives the register port, pins and flags. */
`timescale 1ns/1ns
`default_nettype none
module rail_enable_gating_logic_test;
    localparam int TPM = 5;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic reg_wr, en;
    logic [5:0] pins;
    logic [9:0] pg;
    logic [1:0] pg_class;
    int err_total = 0;
    int samples_checked = 0;
    int pin_idx[8] = '{0, 1, 4, 3, 2, 3, 5, 0};
    int dly_tab[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    int s, k, p, m1, m2, g, d;
    always #2 core_clk_i = ~core_clk_i;
    rail_enable_gating_logic #(.TICKS_PER_MS(TPM)) dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .control_pin_i(pins), .power_good_flag_i(pg), .switch_ldo_group_en_o(en),
        .pg_voltage_class_o(pg_class));
    host_model host_u (.clk_i(core_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .control_pin_o(pins), .power_good_flag_o(pg));
    // reference: selected source and all unmasked flags good
    function automatic int exp_en(int sel, int pv, int a, int b, int gv);
        int src;
        int msk;
        src = (sel == 7) ? 1 : (sel == 5) ? ((pv >> 2) & (pv >> 3) & 1) : ((pv >> pin_idx[sel]) & 1);
        msk = a | ((b & 3) << 8);
        return (src != 0 && ((gv | msk) & 32'h3FF) == 32'h3FF) ? 1 : 0;
    endfunction
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t read %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_en(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t enable %b exp %b", $time, got, exp);
        end
    endtask
    // delay counts judged against a plus/minus ten percent window
    task automatic chk_dly(input logic lvl, input int nom);
        int n;
        n = 0;
        while (en !== lvl && n < 400) begin
            @(negedge core_clk_i);
            n++;
        end
        samples_checked++;
        if (n < nom * 9 / 10 + 3 || n > nom * 11 / 10 + 4) begin
            err_total++;
            $display("[FAIL] %0t edge delay %0d cycles nominal %0d", $time, n, nom);
        end
        if (n >= 400) stop_test();
    endtask
    // synchroniser plus state register, with margin
    task automatic settle();
        repeat (6) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask
    initial begin
        void'($urandom(93));
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        // reset values, and the unmapped place reads zero
        for (d = 8'h25; d <= 8'h28; d++) begin
            host_u.rd(d[7:0], rv);
            chk_reg(rv, 8'h00);
        end
        // a random byte, reserved bits included, reads back from each register
        for (d = 8'h25; d <= 8'h28; d++) begin
            g = $urandom & 255;
            host_u.wr(d[7:0], g[7:0]);
            host_u.rd(d[7:0], rv);
            chk_reg(rv, (d == 8'h28) ? 8'h00 : g[7:0]);
        end
        // every source code and class, all flags masked off
        host_u.wr(8'h25, 8'hFF);
        host_u.wr(8'h27, 8'h00);
        for (s = 0; s < 8; s++) begin
            for (k = 0; k < 4; k++) begin
                // all off, random, only the chosen pin off, all on
                p = (k == 0) ? 0 : (k == 1) ? ($urandom & 63) : (k == 2) ? (63 ^ (1 << pin_idx[s])) : 63;
                host_u.wr(8'h26, 8'(s * 4 + k * 32 + 3));
                host_u.drive(p[5:0], 10'h000);
                settle();
                chk_en(en, exp_en(s, p, 255, 3, 0) != 0);
                chk_reg({6'h00, pg_class}, 8'(k));
            end
        end
        // random masks against at most one failing flag (none when the shift is 10 or 11), source forced on
        for (k = 0; k < 40; k++) begin
            m1 = $urandom & 255;
            m2 = $urandom & 3;
            g = 32'h3FF & ~(1 << ($urandom % 12));
            host_u.wr(8'h25, m1[7:0]);
            host_u.wr(8'h26, 8'(28 + m2));
            host_u.drive(6'h00, g[9:0]);
            settle();
            chk_en(en, exp_en(7, 0, m1, m2, g) != 0);
        end
        // rise and fall delays for every code, on pin 1
        host_u.wr(8'h25, 8'hFF);
        host_u.wr(8'h26, 8'h03);
        host_u.drive(6'h00, 10'h000);
        settle();
        // rise and fall codes differ so a swapped field shows
        for (d = 0; d < 8; d++) begin
            host_u.wr(8'h27, 8'(d + (7 - d) * 8));
            host_u.drive(6'h01, 10'h000);
            chk_dly(1'b1, dly_tab[d] * TPM);
            host_u.drive(6'h00, 10'h000);
            chk_dly(1'b0, dly_tab[7 - d] * TPM);
        end
        // group on from pin 1, then a mid-run reset
        host_u.wr(8'h27, 8'h00);
        host_u.drive(6'h01, 10'h000);
        settle();
        chk_en(en, 1'b1);
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        host_u.drive(6'h00, 10'h000);
        for (d = 8'h25; d <= 8'h27; d++) begin
            host_u.rd(d[7:0], rv);
            chk_reg(rv, 8'h00);
        end
        chk_en(en, 1'b0);
        // forced source from the off state, flags masked
        host_u.wr(8'h25, 8'hFF);
        host_u.wr(8'h26, 8'h1F);
        settle();
        chk_en(en, 1'b1);
        stop_test();
    end
endmodule // rail_enable_gating_logic_test
`default_nettype wire
